// ===== shared/phy10_pkg.sv
// constants and carrier types for the 10 Mb/s mii transceiver timing block
package phy10_pkg;
   localparam int CLK_NS = 4;
   localparam int NS_PER_MS = 1_000_000;
   localparam int HALF_NS = 200;
   localparam int RXCLK_MIN_NS = 160;
   localparam int BIT_NS = 100;
   localparam int TX_LAT_TENTHS = 58;
   localparam int EOP_MIN_NS = 250;
   localparam int EOP_TYP_NS = 310;
   localparam int CRS_TYP_NS = 550;
   localparam int CRS_MAX_NS = 1000;
   localparam int RX_LAT_BITS = 14;
   localparam int NLP_PERIOD_MS = 16;
   localparam int NLP_WIDTH_NS = 100;
   localparam int NIB_BITS = 4;

   localparam int HALF_CYC = HALF_NS / CLK_NS;
   localparam int RXCLK_MIN_CYC = (RXCLK_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int BIT_CYC = BIT_NS / CLK_NS;
   localparam int TX_LAT_CYC = (TX_LAT_TENTHS * BIT_NS) / (10 * CLK_NS);
   localparam int EOP_MIN_CYC = (EOP_MIN_NS + CLK_NS - 1) / CLK_NS;
   localparam int EOP_CYC = (EOP_TYP_NS + CLK_NS - 1) / CLK_NS;
   localparam int CRS_CYC = (CRS_TYP_NS + CLK_NS - 1) / CLK_NS;
   localparam int CRS_MAX_CYC = CRS_MAX_NS / CLK_NS;
   localparam int RX_LAT_CYC = RX_LAT_BITS * BIT_CYC;
   localparam int NLP_WIDTH_CYC = NLP_WIDTH_NS / CLK_NS;
   localparam int NLP_PERIOD_CYC = NLP_PERIOD_MS * NS_PER_MS / CLK_NS;

   localparam logic [1:0] LINE_IDLE = 2'h0;
   localparam logic [1:0] LINE_LOW = 2'h1;
   localparam logic [1:0] LINE_HIGH = 2'h2;
   localparam logic [7:0] SFD_PATTERN = 8'hab;

   typedef struct packed {
      logic en;
      logic [3:0] d;
   } mii_tx_t;

   typedef struct packed {
      logic dv;
      logic [3:0] d;
   } mii_rx_t;

   typedef struct packed {
      logic sfd;
      logic fin;
      logic wv;
      logic [3:0] d;
   } rx_ev_t;
endpackage

// ===== logic/sync3.sv
// three-stage synchroniser, output moves when stages two and three agree
module sync3 #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;

   if (W < 1) begin : g_chk
      $error("sync3 width must be at least one");
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         q <= '0;
      end else if (s2_r == s3_r) begin
         q <= s3_r;
      end
   end
endmodule

// ===== logic/ten_mbps_phy.sv
// 10 Mb/s mii clocking, transmit/receive latency, link pulses
// Notes on behaviour
// - capture txd and tx_en on falling tx_clk
// - tx_clk 200 ns high, 200 ns low
// - rx_clk 200 ns high, 200 ns low
// - rx_clk phases never below 160 ns
// - first line bit 5.8 bits after sample
// - line held high 250-310 ns after frame
// - carrier sense 550 ns, at most 1000 ns
// - rx_dv 14 bits after start delimiter
// - receive nibbles appear 14 bits after each nibble ends on the line
// - idle link pulses 100 ns every 16 ms
module ten_mbps_phy #(
   parameter int NLP_PERIOD = phy10_pkg::NLP_PERIOD_CYC
) (
   // system clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // mii transmit
   output logic tx_clk,
   input wire phy10_pkg::mii_tx_t mii_tx,
   // mii receive
   output logic rx_clk,
   output phy10_pkg::mii_rx_t mii_rx,
   output logic crs,
   // line
   output logic [1:0] line_transmit_pair,
   input wire logic line_rx_clk,
   input wire logic [1:0] line_receive_pair
);
   import phy10_pkg::*;

   localparam int TXD = TX_LAT_CYC - 1;
   localparam int NW = $clog2(NLP_PERIOD + 1);
   localparam logic [6:0] PH_LAST = 7'(HALF_CYC - 1);
   localparam logic [4:0] BIT_LAST = 5'(BIT_CYC - 1);
   localparam logic [6:0] EOP_LOAD = 7'(EOP_CYC - 1);
   localparam logic [7:0] CRS_LAST = 8'(CRS_CYC);
   localparam logic [4:0] NLP_LOAD = 5'(NLP_WIDTH_CYC);
   localparam logic [NW-1:0] NLP_LAST = NW'(NLP_PERIOD - 1);
   localparam int HC = HALF_CYC;
   localparam int TXL = TX_LAT_CYC + 1;
   localparam int EOPM = EOP_MIN_CYC - 1;
   localparam int CRSM = CRS_MAX_CYC;
   localparam int RXL = RX_LAT_CYC;
   localparam int RXH = RX_LAT_CYC + 2 * HALF_CYC + 2;
   localparam int NLPW = NLP_WIDTH_CYC - 1;

   if (NLP_PERIOD <= NLP_WIDTH_CYC + 2 || TXD < 1) begin : g_chk
      $error("link pulse period or transmit latency too short");
   end

   function automatic logic [1:0] line_code(input logic act, input logic b,
                                            input logic hold_high);
      if (act) begin
         return b ? LINE_HIGH : LINE_LOW;
      end
      return hold_high ? LINE_HIGH : LINE_IDLE;
   endfunction

   // mii clock generation
   logic [6:0] ph_r;
   logic tx_clk_r;
   logic rx_clk_r;
   logic ph_last;
   logic tx_fall;
   logic rx_fall;
   assign ph_last = (ph_r == PH_LAST);
   assign tx_fall = tx_clk_r && ph_last;
   assign rx_fall = rx_clk_r && ph_last;
   assign tx_clk = tx_clk_r;
   assign rx_clk = rx_clk_r;

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ph_r <= '0;
      end else begin
         ph_r <= ph_last ? 7'h00 : ph_r + 7'h01;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tx_clk_r <= 1'b0;
      end else if (ph_last) begin
         tx_clk_r <= ~tx_clk_r;
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_clk_r <= 1'b0;
      end else if (ph_last) begin
         rx_clk_r <= ~rx_clk_r;
      end
   end

   // transmit capture and serialiser
   mii_tx_t tx_s;
   logic ser_act_r;
   logic [3:0] shift_r;
   logic [4:0] bit_ph_r;

   sync3 #(.W(5)) u_tx_sync (
      .clk(clk_sys),
      .rst(rst),
      .d(mii_tx),
      .q(tx_s)
   );

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ser_act_r <= 1'b0;
         shift_r <= '0;
         bit_ph_r <= '0;
      end else if (tx_fall) begin
         ser_act_r <= tx_s.en;
         shift_r <= tx_s.d;
         bit_ph_r <= '0;
      end else if (bit_ph_r == BIT_LAST) begin
         shift_r <= shift_r >> 1;
         bit_ph_r <= '0;
      end else begin
         bit_ph_r <= bit_ph_r + 5'h01;
      end
   end

   logic [1:0] tx_dly_r [TXD];
   logic tail_act;
   logic tail_act_q_r;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < TXD; i++) begin
            tx_dly_r[i] <= '0;
         end
      end else begin
         tx_dly_r[0] <= {ser_act_r, shift_r[0]};
         for (int i = 1; i < TXD; i++) begin
            tx_dly_r[i] <= tx_dly_r[i-1];
         end
      end
   end
   assign tail_act = tx_dly_r[TXD-1][1];

   logic [6:0] eop_cnt_r;
   logic eop_start;
   logic eop_now;
   assign eop_start = tail_act_q_r && !tail_act;
   assign eop_now = eop_start || (eop_cnt_r != 7'h00);
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tail_act_q_r <= 1'b0;
         eop_cnt_r <= '0;
      end else begin
         tail_act_q_r <= tail_act;
         if (eop_start) begin
            eop_cnt_r <= EOP_LOAD;
         end else if (tail_act) begin
            eop_cnt_r <= '0;
         end else if (eop_cnt_r != 7'h00) begin
            eop_cnt_r <= eop_cnt_r - 7'h01;
         end
      end
   end

   logic [NW-1:0] nlp_cnt_r;
   logic [4:0] nlp_w_r;
   logic tx_busy;
   logic nlp_go;
   assign tx_busy = ser_act_r || tail_act || eop_now;
   assign nlp_go = !tx_busy && (nlp_cnt_r == NLP_LAST);
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         nlp_cnt_r <= '0;
         nlp_w_r <= '0;
      end else begin
         nlp_cnt_r <= (tx_busy || nlp_go) ? '0 : nlp_cnt_r + 1'b1;
         if (nlp_go) begin
            nlp_w_r <= NLP_LOAD;
         end else if (nlp_w_r != 5'h00) begin
            nlp_w_r <= nlp_w_r - 5'h01;
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         line_transmit_pair <= LINE_IDLE;
      end else begin
         line_transmit_pair <= line_code(tail_act, tx_dly_r[TXD-1][0],
                                         eop_now || (nlp_w_r != 5'h00));
      end
   end

   // line receive front end, link clock domain
   logic lk_act;
   logic lk_bit;
   logic [7:0] lk_hist_r;
   logic lk_in_frame_r;
   logic [1:0] lk_nc_r;
   logic [3:0] lk_nib_r;
   logic [3:0] lk_word_r;
   logic lk_sfd_tog_r;
   logic lk_word_tog_r;
   logic lk_act_r;
   assign lk_act = (line_receive_pair != LINE_IDLE);
   assign lk_bit = (line_receive_pair == LINE_HIGH);

   always_ff @(posedge line_rx_clk or posedge rst) begin
      if (rst) begin
         lk_hist_r <= '0;
         lk_act_r <= 1'b0;
      end else begin
         lk_hist_r <= lk_act ? {lk_hist_r[6:0], lk_bit} : 8'h00;
         lk_act_r <= lk_act;
      end
   end

   always_ff @(posedge line_rx_clk or posedge rst) begin
      if (rst) begin
         lk_in_frame_r <= 1'b0;
         lk_nc_r <= '0;
         lk_nib_r <= '0;
         lk_word_r <= '0;
         lk_sfd_tog_r <= 1'b0;
         lk_word_tog_r <= 1'b0;
      end else if (!lk_act) begin
         lk_in_frame_r <= 1'b0;
         lk_nc_r <= '0;
      end else if (!lk_in_frame_r) begin
         if ({lk_hist_r[6:0], lk_bit} == SFD_PATTERN) begin
            lk_in_frame_r <= 1'b1;
            lk_sfd_tog_r <= ~lk_sfd_tog_r;
            lk_nc_r <= '0;
         end
      end else begin
         lk_nib_r <= {lk_bit, lk_nib_r[3:1]};
         lk_nc_r <= lk_nc_r + 2'h1;
         if (lk_nc_r == 2'(NIB_BITS - 1)) begin
            lk_word_r <= {lk_bit, lk_nib_r[3:1]};
            lk_word_tog_r <= ~lk_word_tog_r;
         end
      end
   end

   // receive events into the system domain
   logic [2:0] rx_s;
   logic [2:0] rx_q_r;
   logic sfd_ev;
   logic word_ev;
   logic act_s;
   rx_ev_t rx_in;
   rx_ev_t rx_dly_r [RXL];
   rx_ev_t rx_tail;

   sync3 #(.W(3)) u_rx_sync (
      .clk(clk_sys),
      .rst(rst),
      .d({lk_act_r, lk_sfd_tog_r, lk_word_tog_r}),
      .q(rx_s)
   );

   assign act_s = rx_s[2];
   assign sfd_ev = rx_s[1] ^ rx_q_r[1];
   assign word_ev = rx_s[0] ^ rx_q_r[0];
   assign rx_in = '{sfd: sfd_ev, fin: rx_q_r[2] && !act_s, wv: word_ev,
                    d: word_ev ? lk_word_r : 4'h0};
   assign rx_tail = rx_dly_r[RXL-1];

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_q_r <= '0;
         for (int i = 0; i < RXL; i++) begin
            rx_dly_r[i] <= '0;
         end
      end else begin
         rx_q_r <= rx_s;
         rx_dly_r[0] <= rx_in;
         for (int i = 1; i < RXL; i++) begin
            rx_dly_r[i] <= rx_dly_r[i-1];
         end
      end
   end

   logic [7:0] crs_cnt_r;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         crs_cnt_r <= '0;
         crs <= 1'b0;
      end else begin
         if (!act_s) begin
            crs_cnt_r <= '0;
         end else if (crs_cnt_r != CRS_LAST) begin
            crs_cnt_r <= crs_cnt_r + 8'h01;
         end
         crs <= act_s && (crs_cnt_r == CRS_LAST);
      end
   end

   logic dv_arm_r;
   logic pend_r;
   logic [3:0] pend_d_r;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         dv_arm_r <= 1'b0;
         pend_r <= 1'b0;
         pend_d_r <= '0;
         mii_rx <= '0;
      end else begin
         if (rx_tail.sfd) begin
            dv_arm_r <= 1'b1;
         end else if (rx_tail.fin) begin
            dv_arm_r <= 1'b0;
         end
         if (rx_tail.wv) begin
            pend_r <= 1'b1;
            pend_d_r <= rx_tail.d;
         end else if (rx_fall) begin
            pend_r <= 1'b0;
         end
         if (rx_fall) begin
            // dv stays up while a last nibble is still pending
            mii_rx.dv <= dv_arm_r || pend_r;
            if (pend_r) begin
               mii_rx.d <= pend_d_r;
            end
         end
      end
   end

   // checks
   logic [7:0] rx_low_cnt_r;
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rx_low_cnt_r <= '0;
      end else if (rx_clk_r) begin
         rx_low_cnt_r <= '0;
      end else if (rx_low_cnt_r != 8'hff) begin
         rx_low_cnt_r <= rx_low_cnt_r + 8'h01;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   property p_tx_capture;
      tx_fall |=> ser_act_r == $past(tx_s.en) && shift_r == $past(tx_s.d);
   endproperty
   a_tx_capture: assert property (p_tx_capture)
      else $error("transmit inputs not captured at falling tx_clk");

   property p_tx_half;
      $rose(tx_clk_r) |-> ##HC $fell(tx_clk_r);
   endproperty
   a_tx_half: assert property (p_tx_half)
      else $error("tx_clk high phase wrong");

   property p_rx_half;
      $fell(rx_clk_r) |-> ##HC $rose(rx_clk_r);
   endproperty
   a_rx_half: assert property (p_rx_half)
      else $error("rx_clk low phase wrong");

   property p_rx_min;
      $rose(rx_clk_r) |-> rx_low_cnt_r >= 8'(RXCLK_MIN_CYC);
   endproperty
   a_rx_min: assert property (p_rx_min)
      else $error("rx_clk low phase below minimum");

   property p_tx_lat;
      tx_fall && tx_s.en && !ser_act_r |-> ##TXL
         (line_transmit_pair == LINE_HIGH || line_transmit_pair == LINE_LOW);
   endproperty
   a_tx_lat: assert property (p_tx_lat)
      else $error("first line bit late");

   property p_eop;
      $fell(tail_act) |=> line_transmit_pair == LINE_HIGH ##EOPM
         line_transmit_pair == LINE_HIGH;
   endproperty
   a_eop: assert property (p_eop)
      else $error("end of packet high time too short");

   property p_crs;
      $rose(act_s) |-> ##[1:CRSM] (crs || !act_s);
   endproperty
   a_crs: assert property (p_crs)
      else $error("carrier sense late");

   property p_dv_lat;
      sfd_ev |-> ##[RXL:RXH] mii_rx.dv;
   endproperty
   a_dv_lat: assert property (p_dv_lat)
      else $error("rx_dv late");

   property p_rxd_lat;
      word_ev |-> ##[RXL:RXH] pend_r;
   endproperty
   a_rxd_lat: assert property (p_rxd_lat)
      else $error("receive nibble not delivered");

   property p_rxd_edge;
      $changed(mii_rx) |-> $past(rx_fall);
   endproperty
   a_rxd_edge: assert property (p_rxd_edge)
      else $error("receive outputs moved off falling rx_clk");

   property p_nlp;
      nlp_go |-> ##2 line_transmit_pair == LINE_HIGH ##NLPW
         line_transmit_pair == LINE_HIGH;
   endproperty
   a_nlp: assert property (p_nlp)
      else $error("link pulse width wrong");

   c_tx_frame: cover property ($fell(tail_act));
   c_crs: cover property ($rose(crs));
   c_dv: cover property ($rose(mii_rx.dv));
   c_nlp: cover property (nlp_go);
endmodule

// ===== tb/mac_model.sv
// mac partner model: drives mii transmit, captures mii receive
module mac_model (
   // mii clocks from the phy
   input wire logic tx_clk,
   input wire logic rx_clk,
   // mii data
   output phy10_pkg::mii_tx_t mii_tx,
   input wire phy10_pkg::mii_rx_t mii_rx
);
   timeunit 1ns;
   timeprecision 1ps;
   import phy10_pkg::*;
   logic [3:0] tx_q[$];
   logic [3:0] rx_q[$];
   initial mii_tx = '0;
   always @(posedge tx_clk) begin
      if (tx_q.size() > 0) begin
         mii_tx.en <= 1'h1;
         mii_tx.d <= tx_q.pop_front();
      end else begin
         mii_tx.en <= 1'h0;
         mii_tx.d <= ~mii_tx.d;
      end
   end
   always @(posedge rx_clk) begin
      if (mii_rx.dv === 1'h1) rx_q.push_back(mii_rx.d);
   end
endmodule

// ===== tb/testbench.sv
// self-checking bench for the 10 Mb/s mii timing block
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import phy10_pkg::*;
   localparam int NLP = 400;
   logic clk_sys, rst, tx_clk, rx_clk, crs, line_rx_clk;
   mii_tx_t mii_tx;
   mii_rx_t mii_rx;
   logic [1:0] line_tx, line_rx;
   int err_total, compares;
   time t_sfd;

   ten_mbps_phy #(.NLP_PERIOD(NLP)) dut_u (
      .clk_sys(clk_sys), .rst(rst), .tx_clk(tx_clk), .mii_tx(mii_tx),
      .rx_clk(rx_clk), .mii_rx(mii_rx), .crs(crs),
      .line_transmit_pair(line_tx), .line_rx_clk(line_rx_clk),
      .line_receive_pair(line_rx));
   mac_model mac_u (.tx_clk(tx_clk), .rx_clk(rx_clk), .mii_tx(mii_tx),
      .mii_rx(mii_rx));

   initial begin
      clk_sys = 1'h0;
      forever #2 clk_sys = ~clk_sys;
   end

   task automatic tick(input int n = 1);
      repeat (n) begin
         @(posedge clk_sys);
         #1;
      end
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("compares=%0d err_total=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   function automatic logic pick(input int sel);
      case (sel)
         0: return tx_clk;
         1: return rx_clk;
         2: return crs;
         default: return mii_rx.dv;
      endcase
   endfunction

   task automatic wait_for(input int sel, input logic v, output int n);
      n = 0;
      while (pick(sel) !== v && n < 3000) begin
         tick();
         n++;
      end
   endtask

   task automatic line_wait(input logic [1:0] v, input bit eq,
      output int n);
      n = 0;
      while ((line_tx === v) != eq && n < 2000) begin
         tick();
         n++;
      end
   endtask

   task automatic t_clocks;
      int n;
      wait_for(0, 1'h1, n);
      wait_for(0, 1'h0, n);
      chk(n, HALF_CYC);
      wait_for(0, 1'h1, n);
      chk(n, HALF_CYC);
      chk(rx_clk, tx_clk);
      wait_for(1, 1'h0, n);
      chk(n, HALF_CYC);
      chk(n >= RXCLK_MIN_CYC, 1'h1);
   endtask

   task automatic t_nlp;
      int n;
      line_wait(2'h2, 1, n);
      chk(n < NLP + 30, 1'h1);
      line_wait(2'h2, 0, n);
      chk(n, NLP_WIDTH_CYC);
      line_wait(2'h2, 1, n);
      n = n + NLP_WIDTH_CYC;
      chk(n >= NLP && n <= NLP + 30, 1'h1);
   endtask

   task automatic t_tx(input logic [3:0] a, input logic [3:0] b);
      int n;
      logic [7:0] bits;
      bits = {b, a};
      wait_for(0, 1'h1, n);
      mac_u.tx_q.push_back(a);
      mac_u.tx_q.push_back(b);
      wait_for(0, 1'h0, n);
      wait_for(0, 1'h1, n);
      wait_for(0, 1'h0, n);
      line_wait(2'h0, 0, n);
      chk(n, TX_LAT_CYC);
      tick(12);
      for (int i = 0; i < 8; i++) begin
         chk(line_tx, bits[i] ? 2'h2 : 2'h1);
         tick(BIT_CYC);
      end
      chk(line_tx, 2'h2);
      line_wait(2'h2, 0, n);
      chk(n + 12, EOP_CYC);
      chk(line_tx, 2'h0);
   endtask

   task automatic send_bit(input logic [1:0] v);
      line_rx = v;
      #12 line_rx_clk = 1'h1;
      #24 line_rx_clk = 1'h0;
      #64;
   endtask

   task automatic t_rx;
      logic [3:0] nib[4];
      int n;
      nib = '{4'h5, 4'hd, 4'h0, 4'hf};
      mac_u.rx_q.delete();
      fork
         begin
            for (int i = 0; i < 4; i++) send_bit(i[0] ? 2'h1 : 2'h2);
            for (int i = 7; i >= 0; i--) begin
               if (i == 0) t_sfd = $time + 12;
               send_bit(SFD_PATTERN[i] ? 2'h2 : 2'h1);
            end
            for (int k = 0; k < 4; k++) begin
               for (int b = 0; b < 4; b++) begin
                  send_bit(nib[k][b] ? 2'h2 : 2'h1);
               end
            end
            send_bit(2'h0);
         end
         begin
            @(posedge line_rx_clk);
            wait_for(2, 1'h1, n);
            chk(n > 0 && n <= CRS_MAX_CYC, 1'h1);
            wait_for(3, 1'h1, n);
            n = int'(($time - t_sfd) / CLK_NS);
            chk(n >= RX_LAT_CYC && n <= RX_LAT_CYC + 110, 1'h1);
            chk(crs, 1'h1);
            wait_for(3, 1'h0, n);
            chk(n < 3000, 1'h1);
            wait_for(2, 1'h0, n);
            chk(n < 3000, 1'h1);
         end
      join
      chk(mac_u.rx_q.size() >= 5, 1'h1);
      for (int i = 0; i < 4; i++) begin
         chk(mac_u.rx_q[i + 1], nib[i]);
      end
   endtask

   initial begin
      rst = 1'h1;
      line_rx = 2'h0;
      line_rx_clk = 1'h0;
      err_total = 0;
      compares = 0;
      tick(2);
      chk({tx_clk, rx_clk, crs, mii_rx, line_tx}, 32'h0000_0000);
      rst = 1'h0;
      t_clocks();
      t_nlp();
      t_tx(4'h5, 4'h3);
      t_tx(4'ha, 4'hc);
      t_rx();
      tally_and_finish();
   end

   initial begin
      #200_000;
      err_total++;
      tally_and_finish();
   end
endmodule
